//--- design/twd_pkg.sv
package twd_pkg;

   // register byte offsets on the apb slave
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_MASK      = 8'h08;
   localparam logic [7:0]  OFS_COUNT     = 8'h0C;

   // control register fields
   localparam int          CTRL_NOSTOP_BIT = 6;
   localparam int          CTRL_SHORT_BIT  = 7;
   localparam logic [5:0]  CTRL_LOW_READ   = 6'h3F;

   // status and mask fields
   localparam int          STS_W         = 2;
   localparam int          STS_UNDERFLOW = 0;
   localparam int          STS_ILLEGAL   = 1;

   // counter stages
   localparam int          LOW_W       = 8;
   localparam int          HIGH_W      = 12;
   localparam logic [7:0]  LOW_RELOAD  = 8'hFF;
   localparam logic [11:0] HIGH_RELOAD = 12'hFFF;
   localparam logic [7:0]  LOW_ZERO    = 8'h00;
   localparam logic [11:0] HIGH_ZERO   = 12'h000;

   // prescaler in front of the low stage, divide by 16
   localparam int          PRE_W       = 4;
   localparam logic [3:0]  PRE_MAX     = 4'hF;
   localparam logic [3:0]  PRE_ZERO    = 4'h0;

   // periods in clk_sys cycles from a control write to the high stage underflow
   localparam int          CLK_PERIOD_NS  = 4;
   localparam longint      LONG_PERIOD_CYC  = longint'(PRE_MAX + 1) * 256 * 4096;
   localparam longint      SHORT_PERIOD_CYC = longint'(PRE_MAX + 1) * 4096;

   // restart vector pair, low byte at the lower address
   localparam logic [15:0] VEC_LO_ADDR = 16'hFFFC;
   localparam logic [15:0] VEC_HI_ADDR = 16'hFFFD;

   typedef struct packed {
      logic              ctrl_short;
      logic              ctrl_nostop;
      logic              running;
      logic              stopped;
      logic [3:0]        pre;
      logic [7:0]        low;
      logic [11:0]       high;
      logic [STS_W-1:0]  sts;
      logic [STS_W-1:0]  msk;
      logic              irq;
      logic              rst_req;
      logic              boot;
      logic              restart;
      logic [15:0]       vec_addr;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } twd_state_t;

   localparam twd_state_t ST_RST = '{low:      LOW_RELOAD,
                                     high:     HIGH_RELOAD,
                                     boot:     1'b1,
                                     vec_addr: VEC_LO_ADDR,
                                     default:  '0};

endpackage : twd_pkg

//--- design/twd_watchdog.sv
`timescale 1ns/100ps

// Summary of operation
// - watchdog is an 8-bit low stage cascaded into a 12-bit high stage
// - reset and every control write load low with all ones, high with all ones
// - any control write reloads, whatever value sits in bits zero to five
// - only bits six and seven of the control register store written data
// - after reset the watchdog is halted until the first control write
// - high stage underflow raises an internal system reset
// - after any reset, execution restarts from the vector pair fetch
// - with bit six clear the stop instruction halts clock and count
// - counting resumes the moment stop mode is released
// - the count keeps running during the wait state
// - with bit six set the stop instruction is illegal and resets
// - bit six once written to one stays one until the next reset
// - bit seven clear gives the long period to underflow
// - bit seven set gives the short period to underflow
// - counting continues during the settling wait after stop release
module twd_watchdog
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // processor events
   input  wire logic        halt_oscillator_instruction,
   input  wire logic        wait_state_instruction,
   input  wire logic        stop_release,
   // system side
   output logic             osc_halt,
   output logic             sys_reset_req,
   output logic             restart_fetch,
   output logic      [15:0] vector_addr,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////////

   twd_pkg::twd_state_t st_ff;
   twd_pkg::twd_state_t nxt_st;

   logic                      setup;
   logic                      access;
   logic                      wr_ctrl;
   logic                      wr_status;
   logic                      wr_mask;
   logic                      tick;
   logic                      low_uf;
   logic                      high_step;
   logic                      high_uf;
   logic                      stop_ok;
   logic                      stop_bad;
   logic [twd_pkg::STS_W-1:0] events;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr[7:2] == ofs[7:2]);
   endfunction : hit

   function automatic logic mapped(input logic [7:0] addr);
      mapped = hit(addr, twd_pkg::OFS_CTRL) | hit(addr, twd_pkg::OFS_STATUS)
             | hit(addr, twd_pkg::OFS_MASK) | hit(addr, twd_pkg::OFS_COUNT);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode: setup cycle loads pready, write takes effect at the access edge

   assign setup     = psel & ~penable;
   assign access    = psel & penable & st_ff.pready;
   assign wr_ctrl   = access & pwrite & hit(paddr, twd_pkg::OFS_CTRL);
   assign wr_status = access & pwrite & hit(paddr, twd_pkg::OFS_STATUS);
   assign wr_mask   = access & pwrite & hit(paddr, twd_pkg::OFS_MASK);

   ////////////////////////////////////////////////////////////////////////////////
   // counter chain

   assign tick      = st_ff.running & ~st_ff.stopped & (st_ff.pre == twd_pkg::PRE_MAX);
   assign low_uf    = tick & (st_ff.low == twd_pkg::LOW_ZERO);
   assign high_step = st_ff.ctrl_short ? tick : low_uf;
   assign high_uf   = high_step & (st_ff.high == twd_pkg::HIGH_ZERO);
   assign stop_ok   = halt_oscillator_instruction & ~st_ff.ctrl_nostop;
   assign stop_bad  = halt_oscillator_instruction & st_ff.ctrl_nostop;

   always_comb
   begin
      events                           = '0;
      events[twd_pkg::STS_UNDERFLOW]   = high_uf;
      events[twd_pkg::STS_ILLEGAL]     = stop_bad;
   end

   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.pready  = setup;
      nxt_st.pslverr = 1'b0;
      nxt_st.rst_req = 1'b0;
      nxt_st.boot    = 1'b0;
      nxt_st.restart = st_ff.boot | st_ff.rst_req;
      nxt_st.vec_addr = twd_pkg::VEC_LO_ADDR;

      // read data and error are prepared in the setup cycle
      if (setup)
      begin
         nxt_st.prdata  = '0;
         nxt_st.pslverr = ~mapped(paddr);
         if (!pwrite)
         begin
            if (hit(paddr, twd_pkg::OFS_CTRL))
            begin
               nxt_st.prdata[7:0] = {st_ff.ctrl_short, st_ff.ctrl_nostop,
                                     twd_pkg::CTRL_LOW_READ};
            end
            else if (hit(paddr, twd_pkg::OFS_STATUS))
            begin
               nxt_st.prdata[twd_pkg::STS_W-1:0] = st_ff.sts;
            end
            else if (hit(paddr, twd_pkg::OFS_MASK))
            begin
               nxt_st.prdata[twd_pkg::STS_W-1:0] = st_ff.msk;
            end
            else if (hit(paddr, twd_pkg::OFS_COUNT))
            begin
               nxt_st.prdata[19:0] = {st_ff.high, st_ff.low};
            end
         end
      end

      // prescaler and stages run through wait, stop them in stop mode and while not running
      if (st_ff.running && !st_ff.stopped)
      begin
         nxt_st.pre = st_ff.pre + 4'h1;
      end
      if (tick)
      begin
         nxt_st.low = st_ff.low - 8'h01;
      end
      if (high_step)
      begin
         nxt_st.high = st_ff.high - 12'h001;
      end

      // stop mode, released straight into counting through the settling wait
      if (stop_ok)
      begin
         nxt_st.stopped = 1'b1;
      end
      if (stop_release)
      begin
         nxt_st.stopped = 1'b0;
      end

      if (wr_ctrl)
      begin
         nxt_st.low         = twd_pkg::LOW_RELOAD;
         nxt_st.high        = twd_pkg::HIGH_RELOAD;
         nxt_st.pre         = twd_pkg::PRE_ZERO;
         nxt_st.running     = 1'b1;
         nxt_st.ctrl_short  = pwdata[twd_pkg::CTRL_SHORT_BIT];
         nxt_st.ctrl_nostop = st_ff.ctrl_nostop | pwdata[twd_pkg::CTRL_NOSTOP_BIT];
      end

      if (wr_mask)
      begin
         nxt_st.msk = pwdata[twd_pkg::STS_W-1:0];
      end
      // new events win over a clear in the same cycle
      nxt_st.sts = (st_ff.sts & ~(wr_status ? pwdata[twd_pkg::STS_W-1:0] : '0)) | events;

      // internal reset puts the timer back to its reset condition
      if (|events)
      begin
         nxt_st.rst_req     = 1'b1;
         nxt_st.running     = 1'b0;
         nxt_st.stopped     = 1'b0;
         nxt_st.ctrl_short  = 1'b0;
         nxt_st.ctrl_nostop = 1'b0;
         nxt_st.pre         = twd_pkg::PRE_ZERO;
         nxt_st.low         = twd_pkg::LOW_RELOAD;
         nxt_st.high        = twd_pkg::HIGH_RELOAD;
      end

      nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         st_ff <= twd_pkg::ST_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign prdata        = st_ff.prdata;
   assign pready        = st_ff.pready;
   assign pslverr       = st_ff.pslverr;
   assign osc_halt      = st_ff.stopped;
   assign sys_reset_req = st_ff.rst_req;
   assign restart_fetch = st_ff.restart;
   assign vector_addr   = st_ff.vec_addr;
   assign irq           = st_ff.irq;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_ctrl_write;
      wr_ctrl && !halt_oscillator_instruction && !high_uf;
   endsequence

   sequence s_reload_seen;
      (st_ff.low == twd_pkg::LOW_RELOAD) && (st_ff.high == twd_pkg::HIGH_RELOAD)
      && st_ff.running;
   endsequence

   sequence s_internal_reset;
      st_ff.rst_req && !st_ff.running;
   endsequence

   AST_RELOAD_ON_WRITE: assert property (s_ctrl_write |=> s_reload_seen)
      else $error("control write did not reload both stages");

   AST_ANY_DATA_RELOADS: assert property
      (s_ctrl_write |=> (st_ff.pre == twd_pkg::PRE_ZERO) && st_ff.running)
      else $error("control write with arbitrary low bits did not start count");

   AST_STORE_HIGH_BITS: assert property
      (s_ctrl_write |=> st_ff.ctrl_short == $past(pwdata[twd_pkg::CTRL_SHORT_BIT]))
      else $error("period select bit not stored from write data");

   AST_HALTED_UNTIL_WRITE: assert property
      (!st_ff.running && !wr_ctrl |=> $stable(st_ff.low) && $stable(st_ff.high)
                                      && !sys_reset_req)
      else $error("watchdog counted before first control write");

   AST_UNDERFLOW_RESETS: assert property
      (high_uf |=> s_internal_reset ##1 restart_fetch)
      else $error("high stage underflow did not raise internal reset");

   AST_RESTART_VECTOR: assert property
      (restart_fetch |-> vector_addr == twd_pkg::VEC_LO_ADDR
                         && ($past(sys_reset_req) || $past(st_ff.boot)))
      else $error("restart fetch without preceding reset or wrong vector");

   AST_STOP_HALTS: assert property
      (st_ff.stopped && !stop_release && !wr_ctrl && !stop_bad
       |=> $stable(st_ff.pre) && $stable(st_ff.low) && $stable(st_ff.high))
      else $error("count moved while in stop mode");

   AST_RELEASE_COUNTS: assert property
      (st_ff.running && st_ff.stopped && stop_release && !halt_oscillator_instruction
       && !wr_ctrl |=> !osc_halt ##1 (st_ff.pre != $past(st_ff.pre)))
      else $error("count did not resume at stop release");

   AST_WAIT_COUNTS: assert property
      (st_ff.running && !st_ff.stopped && wait_state_instruction && !wr_ctrl
       && !halt_oscillator_instruction && !high_uf
       |=> st_ff.pre == $past(st_ff.pre) + 4'h1)
      else $error("count stopped during wait state");

   AST_ILLEGAL_STOP: assert property
      (stop_bad |=> sys_reset_req && st_ff.sts[twd_pkg::STS_ILLEGAL] && !osc_halt)
      else $error("disabled stop instruction did not force reset");

   AST_NOSTOP_STICKY: assert property
      (st_ff.ctrl_nostop && !(|events) |=> st_ff.ctrl_nostop)
      else $error("stop disable bit cleared without reset");

   AST_SHORT_BYPASS: assert property
      (tick && st_ff.ctrl_short && !wr_ctrl && !(|events)
       |=> st_ff.high == $past(st_ff.high) - 12'h001)
      else $error("short period did not step high stage directly");

   AST_LONG_CASCADE: assert property
      (tick && !st_ff.ctrl_short && (st_ff.low != twd_pkg::LOW_ZERO) && !wr_ctrl
       |=> $stable(st_ff.high))
      else $error("long period stepped high stage without low underflow");

   AST_IRQ_LEVEL: assert property
      (irq == |(st_ff.sts & st_ff.msk))
      else $error("interrupt output does not follow masked status");

   AST_IRQ_ON_EVENT: assert property
      ((|(events & st_ff.msk)) && !wr_mask |=> irq)
      else $error("unmasked event did not raise the interrupt");

   // one access cycle answers every setup cycle
   sequence s_apb_answer;
      pready ##1 !pready;
   endsequence

   AST_PREADY_AFTER_SETUP: assert property (setup |=> s_apb_answer)
      else $error("setup cycle was not answered by a one cycle pready");

   AST_PREADY_PULSE: assert property (pready && psel && penable |=> !pready)
      else $error("pready stood longer than one access cycle");

   AST_UNMAPPED_ERROR: assert property
      (setup && (paddr[7:4] != 4'h0) |=> pslverr && (prdata == 32'h00000000))
      else $error("unmapped address did not answer with an error");

   AST_RESERVED_READ_ZERO: assert property
      (setup && !pwrite |=> prdata[31:20] == 12'h000)
      else $error("reserved read data bits were not zero");

   AST_CTRL_LOW_READ: assert property
      (setup && !pwrite && (paddr[7:2] == 6'h00)
       |=> prdata[5:0] == twd_pkg::CTRL_LOW_READ)
      else $error("control register low bits did not read as ones");

   AST_MASK_WRITE: assert property
      (wr_mask |=> st_ff.msk == $past(pwdata[twd_pkg::STS_W-1:0]))
      else $error("mask register did not take the written value");

   AST_STATUS_SET_WINS: assert property
      (high_uf && wr_status && pwdata[twd_pkg::STS_UNDERFLOW]
       |=> st_ff.sts[twd_pkg::STS_UNDERFLOW])
      else $error("status clear won over a new underflow event");

   AST_STOP_ENTERS: assert property
      (stop_ok && !stop_release && !high_uf |=> osc_halt)
      else $error("enabled stop instruction did not enter stop mode");

   AST_RESET_ONLY_ON_EVENT: assert property
      (!(|events) |=> !sys_reset_req)
      else $error("internal reset raised without an event");

   AST_EVENT_CLEARS_CTRL: assert property
      ((|events) |=> !st_ff.ctrl_nostop && !st_ff.ctrl_short && !osc_halt && !st_ff.running)
      else $error("internal reset left the timer configured");

   AST_ILLEGAL_RESTARTS: assert property
      (stop_bad |=> s_internal_reset ##1 restart_fetch)
      else $error("illegal stop was not followed by a restart fetch");

endmodule : twd_watchdog

//--- sim/tb_two_stage_watchdog_timer.sv
`timescale 1ns/100ps

module tb_two_stage_watchdog_timer;

   typedef struct {
      logic        wr;
      logic [7:0]  adr;
      logic [31:0] wd;
      logic [31:0] rd;
      logic        er;
   } twd_row_t;

   logic        clk_sys = 1'b0;
   logic        resetn  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        halt_i  = 1'b0;
   logic        wait_i  = 1'b0;
   logic        rel_i   = 1'b0;
   logic        osc_halt;
   logic        sys_reset_req;
   logic        restart_fetch;
   logic [15:0] vector_addr;
   logic        irq;
   int          fails = 0;
   int          checks_done = 0;
   logic [31:0] v;
   logic [31:0] c;
   logic        e;
   int          n;
   twd_row_t    rows[9];

   always #2 clk_sys = ~clk_sys;

   twd_watchdog dut_u
   (
      .clk_sys                     (clk_sys),
      .resetn                      (resetn),
      .psel                        (psel),
      .penable                     (penable),
      .pwrite                      (pwrite),
      .paddr                       (paddr),
      .pwdata                      (pwdata),
      .prdata                      (prdata),
      .pready                      (pready),
      .pslverr                     (pslverr),
      .halt_oscillator_instruction (halt_i),
      .wait_state_instruction      (wait_i),
      .stop_release                (rel_i),
      .osc_halt                    (osc_halt),
      .sys_reset_req               (sys_reset_req),
      .restart_fetch               (restart_fetch),
      .vector_addr                 (vector_addr),
      .irq                         (irq)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // one apb transfer, request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      v = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse_in(input int which);
      @(posedge clk_sys);
      if (which == 0) halt_i <= 1'b1; else rel_i <= 1'b1;
      @(posedge clk_sys);
      halt_i <= 1'b0;
      rel_i  <= 1'b0;
   endtask : pulse_in

   // waits for the internal reset pulse, n holds the edges counted
   task automatic wait_rst(input int lim);
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (sys_reset_req !== 1'b1 && n < lim);
   endtask : wait_rst

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end

   initial
   begin
      rows = '{'{0, twd_pkg::OFS_CTRL,   32'h0, 32'h3F,    0},
               '{0, twd_pkg::OFS_STATUS, 32'h0, 32'h0,     0},
               '{0, twd_pkg::OFS_MASK,   32'h0, 32'h0,     0},
               '{1, twd_pkg::OFS_MASK,   32'h3, 32'h0,     0},
               '{0, twd_pkg::OFS_MASK,   32'h0, 32'h3,     0},
               '{1, twd_pkg::OFS_COUNT,  32'h0, 32'h0,     0},
               '{1, 8'h10,               32'h5, 32'h0,     1},
               '{0, 8'h10,               32'h0, 32'h0,     1},
               '{0, twd_pkg::OFS_COUNT,  32'h0, 32'hFFFFF, 0}};
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk(restart_fetch, 1'b1);
      chk(vector_addr, 16'hFFFC);
      chk({osc_halt, irq, sys_reset_req}, 3'b000);
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].adr, rows[i].wd);
         chk(e, rows[i].er);
         if (!rows[i].wr) chk(v, rows[i].rd);
      end
      repeat (100) @(posedge clk_sys);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v, 32'hFFFFF);
      // short period with the cpu parked in the wait state
      wait_i <= 1'b1;
      apb(1, twd_pkg::OFS_CTRL, 32'h80);
      wait_rst(70000);
      chk(n > 65530 && n < 65545, 1'b1);
      @(posedge clk_sys);
      chk(restart_fetch, 1'b1);
      wait_i <= 1'b0;
      chk(irq, 1'b1);
      apb(0, twd_pkg::OFS_STATUS, 0);
      chk(v, 32'h1);
      apb(1, twd_pkg::OFS_STATUS, 32'h1);
      @(posedge clk_sys);
      chk(irq, 1'b0);
      chk(pready, 1'b0);
      apb(1, twd_pkg::OFS_MASK, 32'h0);
      // reload on any write, only bits six and seven stored
      apb(1, twd_pkg::OFS_CTRL, 32'h80);
      repeat (200) @(posedge clk_sys);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v[19:8] < 12'hFF8, 1'b1);
      apb(1, twd_pkg::OFS_CTRL, 32'h9F);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v[19:8] >= 12'hFFE && v[7:0] === 8'hFF, 1'b1);
      apb(0, twd_pkg::OFS_CTRL, 0);
      chk(v, 32'hBF);
      // stop freezes the count, release resumes it
      pulse_in(0);
      @(posedge clk_sys);
      chk(osc_halt, 1'b1);
      apb(0, twd_pkg::OFS_COUNT, 0);
      c = v;
      repeat (80) @(posedge clk_sys);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v, c);
      pulse_in(1);
      @(posedge clk_sys);
      chk(osc_halt, 1'b0);
      repeat (80) @(posedge clk_sys);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v[19:8] < c[19:8], 1'b1);
      // sticky stop disable, then an illegal stop
      apb(1, twd_pkg::OFS_CTRL, 32'h40);
      apb(1, twd_pkg::OFS_CTRL, 32'h00);
      // long period: low stage counts, high stage waits for its underflow
      repeat (100) @(posedge clk_sys);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v[19:8], 12'hFFF);
      chk(v[7:0] < 8'hFF, 1'b1);
      apb(0, twd_pkg::OFS_CTRL, 0);
      chk(v, 32'h7F);
      pulse_in(0);
      wait_rst(6);
      chk(sys_reset_req, 1'b1);
      chk(osc_halt, 1'b0);
      apb(0, twd_pkg::OFS_STATUS, 0);
      chk(v, 32'h2);
      apb(0, twd_pkg::OFS_CTRL, 0);
      chk(v, 32'h3F);
      // reset while halted after the illegal stop: restart fetch again, registers back to reset values
      apb(1, twd_pkg::OFS_MASK, 32'h3);
      @(posedge clk_sys);
      chk(irq, 1'b1);
      resetn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      @(posedge clk_sys);
      chk(restart_fetch, 1'b1);
      chk({osc_halt, irq, sys_reset_req}, 3'b000);
      apb(0, twd_pkg::OFS_STATUS, 0);
      chk(v, 32'h0);
      apb(0, twd_pkg::OFS_COUNT, 0);
      chk(v, 32'hFFFFF);
      print_verdict();
   end

endmodule : tb_two_stage_watchdog_timer
